// >>> include/sslr_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the
 switch statistics, VLAN untag and storm limit register bank.
 Assumes byte addressing with one 32-bit word per register.
*/
// Overview of operation
// - With the gig-only arbiter bit (bit 9) set, memory slots go only to ports 5 and 6.
// - The ratio bit gives ports 5,6 versus 0-4 a slot share of 3:2 when clear, 4:1 when set.
// - A set bit of the seven-bit double-tag field lets that port's frames take an outer tag.
// - Port 5 double-tag and storm settings act only when the port 5 gigabit MAC is built in.
// - Ports 0-5 each have a read-only bad frame counter in bits 31:16, reset to zero.
// - Ports 0-5 each have a read-only good frame counter in bits 15:0, reset to zero.
// - Sixteen VLANs each hold a seven-bit untag port mask, four per register, reset zero.
// - A one-microsecond tick is made by counting the programmed number of core cycles.
// - Each port's storm field limits broadcast (bit 2), multicast (bit 1), unknown (bit 0).
// - At 100 Mbit/s at most the fast budget of limited frames pass in each 100 ms.
// - At 10 Mbit/s at most the slow budget of limited frames pass in each 1 s.
// - At 1000 Mbit/s at most the gig budget of limited frames pass in each 10 ms.
// - Ingress metered length adds the byte number when the sign bit is 0, subtracts if 1.
// - Egress metered length adds the byte number when the sign bit is 0, subtracts if 1.
// - Bucket refill period codes 0 to 3 mean 512, 128, 32 and 8 microseconds.
// - Each refill adds the token bytes to the bucket, capped at 65535 bytes.
`ifndef SSLR_DEFS_SVH
`define SSLR_DEFS_SVH
`define SSLR_GC2_OFS 32'h101100E4
`define SSLR_PC0_OFS 32'h101100E8
`define SSLR_PC1_OFS 32'h101100EC
`define SSLR_PC2_OFS 32'h101100F0
`define SSLR_PC3_OFS 32'h101100F4
`define SSLR_PC4_OFS 32'h101100F8
`define SSLR_PC5_OFS 32'h101100FC
`define SSLR_VLAN_UNTAG_MASK_0_3_OFS 32'h10110100
`define SSLR_VLAN_UNTAG_MASK_4_7_OFS 32'h10110104
`define SSLR_VLAN_UNTAG_MASK_8_11_OFS 32'h10110108
`define SSLR_VLAN_UNTAG_MASK_12_15_OFS 32'h1011010C
`define SSLR_CTRL_OFS 32'h10110110
`define SSLR_NUM1_OFS 32'h10110114
`define SSLR_NUM2_OFS 32'h10110118
`define SSLR_ING01_OFS 32'h1011011C
`define SSLR_GIGONLY_BIT 9
`define SSLR_RATIO_BIT 8
`define SSLR_CYC_LSB 24
`define SSLR_IGSIGN_BIT 31
`define SSLR_IGBYTES_LSB 24
`define SSLR_EGSIGN_BIT 23
`define SSLR_EGBYTES_LSB 16
`define SSLR_CTRL_RST 32'h7C000000
`define SSLR_NUM1_RST 32'hFFFFFFFF
`define SSLR_NUM2_RST 32'h1818FFFF
`define SSLR_CTRL_MASK 32'h7F777777
`define SSLR_ING_MASK 32'h7FFF7FFF
`define SSLR_WIN_SLOW_US 20'd1000000
`define SSLR_WIN_FAST_US 20'd100000
`define SSLR_WIN_GIG_US 20'd10000
`define SSLR_TICK0_US 10'd512
`define SSLR_TICK1_US 10'd128
`define SSLR_TICK2_US 10'd32
`define SSLR_TICK3_US 10'd8
`define SSLR_BUCKET_MAX 16'hFFFF
`endif

// >>> include/sslr_pkg.sv
/*
 State types of the statistics and rate limit bank.
 Assumes sslr_defs.svh supplies the numbers.
*/
package sslr_pkg;
	typedef struct packed {
		logic [19:0] winUs;
		logic [15:0] count;
		logic drop;
	} sslr_storm_t;
	typedef struct packed {
		logic [9:0] usCnt;
		logic [15:0] level;
		logic empty;
	} sslr_bucket_t;
	typedef struct packed {
		logic gigOnly;
		logic ratioSel;
		logic [6:0] dblTag;
		logic [5:0][15:0] goodCnt;
		logic [5:0][15:0] badCnt;
		logic [3:0][27:0] vub;
		logic [31:0] ctrl;
		logic [31:0] num1;
		logic [31:0] num2;
		logic [31:0] ing01;
		logic [6:0] usCnt;
		logic usTick;
		logic [2:0] slot;
		logic [2:0] lanPtr;
		logic gigPtr;
		logic [6:0] grant;
		logic [6:0] dblTagOut;
		logic [6:0] untag;
		logic [15:0] ingAdj;
		logic ingAdjValid;
		logic [15:0] egAdj;
		logic egAdjValid;
		logic [31:0] rdata;
	} sslr_top_t;
endpackage

// >>> rtl/sslr_bucket.sv
/*
 Ingress token bucket for one port.
 Assumes a one-cycle microsecond tick and adjusted frame lengths.
*/
`timescale 1ns/1ps
`include "sslr_defs.svh"
module sslr_bucket import sslr_pkg::*; (
	input wire logic clk, // core clock
	input wire logic ce, // clock enable
	input wire logic srst, // sync reset
	input wire logic usTick, // microsecond tick
	input wire logic [1:0] period, // refill period code
	input wire logic [9:0] tokens, // bytes per refill
	input wire logic frameValid, // frame taken from bucket
	input wire logic [15:0] frameLen, // metered length
	output logic empty // bucket at zero
);
	sslr_bucket_t st, nx;
	logic [9:0] perUs;
	logic refill;
	logic [16:0] sum;
	logic [15:0] lvl;
	always_comb begin
		nx = st;
		case (period)
			2'd0: perUs = `SSLR_TICK0_US;
			2'd1: perUs = `SSLR_TICK1_US;
			2'd2: perUs = `SSLR_TICK2_US;
			default: perUs = `SSLR_TICK3_US;
		endcase
		refill = usTick && (st.usCnt >= perUs - 10'h1);
		if (usTick)
			nx.usCnt = refill ? 10'h0 : st.usCnt + 10'h1;
		sum = {1'b0, st.level} + (refill ? {7'h0, tokens} : 17'h0);
		lvl = sum[16] ? `SSLR_BUCKET_MAX : sum[15:0];
		// Refill lands before the frame so a tick never hides a charge
		if (frameValid)
			lvl = (frameLen >= lvl) ? 16'h0000 : lvl - frameLen;
		nx.level = lvl;
		nx.empty = (lvl == 16'h0000);
		if (srst) begin
			nx.usCnt = 10'h0;
			nx.level = `SSLR_BUCKET_MAX;
			nx.empty = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (ce || srst)
			st <= nx;
	end
	assign empty = st.empty;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_cap;
		ce && refill && !frameValid && sum[16] |=> st.level == 16'hFFFF;
	endproperty
	a_cap: assert property (p_cap) else $error("bucket not capped");
	property p_period;
		ce && usTick && !refill |=> st.usCnt == $past(st.usCnt) + 10'h1;
	endproperty
	a_period: assert property (p_period) else $error("refill period miscounted");
endmodule

// >>> rtl/sslr_storm_port.sv
/*
 Per-port broadcast/multicast/unknown storm limiter.
 Assumes a one-cycle microsecond tick and one-cycle frame pulses.
*/
`timescale 1ns/1ps
`include "sslr_defs.svh"
module sslr_storm_port import sslr_pkg::*; #(
	parameter bit PRESENT = 1'b1
) (
	input wire logic clk, // core clock
	input wire logic ce, // clock enable
	input wire logic srst, // sync reset
	input wire logic usTick, // microsecond tick
	input wire logic [2:0] typeEn, // bc, mc, unknown enables
	input wire logic [1:0] speed, // 00 10M, 01 100M, 1x 1G
	input wire logic [15:0] budgetSlow, // frames per 1 s
	input wire logic [15:0] budgetFast, // frames per 100 ms
	input wire logic [15:0] budgetGig, // frames per 10 ms
	input wire logic frameBc, // broadcast frame pulse
	input wire logic frameMc, // multicast frame pulse
	input wire logic frameUn, // unknown frame pulse
	output logic drop // frame over budget
);
	sslr_storm_t st, nx;
	logic limited;
	logic winEnd;
	logic [19:0] winLen;
	logic [15:0] budget;
	logic [15:0] base;
	always_comb begin
		nx = st;
		limited = PRESENT && ((frameBc && typeEn[2]) || (frameMc && typeEn[1])
			|| (frameUn && typeEn[0]));
		case (speed)
			2'b00: begin
				winLen = `SSLR_WIN_SLOW_US;
				budget = budgetSlow;
			end
			2'b01: begin
				winLen = `SSLR_WIN_FAST_US;
				budget = budgetFast;
			end
			default: begin
				winLen = `SSLR_WIN_GIG_US;
				budget = budgetGig;
			end
		endcase
		winEnd = usTick && (st.winUs >= winLen - 20'h1);
		base = winEnd ? 16'h0000 : st.count;
		nx.drop = 1'b0;
		if (usTick)
			nx.winUs = winEnd ? 20'h0 : st.winUs + 20'h1;
		nx.count = base;
		if (limited) begin
			if (base >= budget)
				nx.drop = 1'b1;
			else
				nx.count = base + 16'h1;
		end
		if (srst)
			nx = '0;
	end
	always_ff @(posedge clk) begin
		if (ce || srst)
			st <= nx;
	end
	assign drop = st.drop;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_over;
		ce && limited && !winEnd && st.count >= budget |=> drop;
	endproperty
	a_over: assert property (p_over) else $error("over-budget frame not dropped");
	property p_admit;
		ce && limited && !winEnd && st.count < budget |=>
			!drop && st.count == $past(st.count) + 16'h1;
	endproperty
	a_admit: assert property (p_admit) else $error("in-budget frame mishandled");
	property p_window;
		ce && winEnd && !limited |=> st.count == 16'h0000 && st.winUs == 20'h0;
	endproperty
	a_window: assert property (p_window) else $error("window did not restart");
endmodule

// >>> rtl/sslr_top.sv
/*
 Switch statistics, VLAN untag, storm limit and length adjust bank.
 Assumes a plain register port with read data one cycle later and
 one-cycle event pulses from the port MACs and frame engine.
*/
`timescale 1ns/1ps
`include "sslr_defs.svh"
module sslr_top import sslr_pkg::*; #(
	parameter bit PORT5_PRESENT = 1'b1
) (
	input wire logic clk, // core clock, 25 MHz
	input wire logic ce, // clock enable
	input wire logic srst, // sync reset
	input wire logic [31:0] regAddr, // byte address
	input wire logic [31:0] regWdata, // write data
	input wire logic regWr, // write strobe
	input wire logic regRd, // read strobe
	output logic [31:0] regRdata, // read data, next cycle
	input wire logic [5:0] rxGood, // good frame pulses
	input wire logic [5:0] rxBad, // bad frame pulses
	input wire logic [11:0] portSpeed, // two bits per port
	input wire logic [5:0] frameBc, // broadcast pulses
	input wire logic [5:0] frameMc, // multicast pulses
	input wire logic [5:0] frameUn, // unknown pulses
	output logic [5:0] stormDrop, // drop verdicts
	input wire logic ingValid, // ingress frame pulse
	input wire logic [2:0] ingPort, // ingress port
	input wire logic [15:0] ingLen, // ingress length
	output logic [15:0] ingAdjLen, // adjusted ingress length
	output logic ingAdjValid, // adjusted length valid
	output logic [1:0] bucketEmpty, // ports 0,1 bucket empty
	input wire logic egValid, // egress frame pulse
	input wire logic [15:0] egLen, // egress length
	output logic [15:0] egAdjLen, // adjusted egress length
	output logic egAdjValid, // adjusted length valid
	input wire logic [3:0] vlanIdx, // VLAN entry lookup
	output logic [6:0] untagMask, // untag ports of entry
	output logic [6:0] doubleTagEn, // double tag per port
	output logic [6:0] arbGrant // memory slot owner
);
	sslr_top_t st, nx;
	logic [6:0] cycNum;
	logic [2:0] gigSlots;
	logic [15:0] ingComb;
	logic [6:0] portMask;

	generate
		if (PORT5_PRESENT !== 1'b0 && PORT5_PRESENT !== 1'b1) begin : g_chk
			$error("PORT5_PRESENT must be 0 or 1");
		end
	endgenerate

	function automatic logic [15:0] lenAdj(
		input logic [15:0] len,
		input logic sub,
		input logic [6:0] b
	);
		logic [16:0] s;
		s = sub ? ({1'b0, len} - {10'h0, b}) : ({1'b0, len} + {10'h0, b});
		// Saturate rather than wrap: a wrapped length would meter wildly
		if (s[16])
			lenAdj = sub ? 16'h0000 : 16'hFFFF;
		else
			lenAdj = s[15:0];
	endfunction

	assign portMask = PORT5_PRESENT ? 7'h7F : 7'h5F;

	always_comb begin
		nx = st;
		cycNum = st.ctrl[`SSLR_CYC_LSB +: 7];
		ingComb = lenAdj(ingLen, st.num2[`SSLR_IGSIGN_BIT],
			st.num2[`SSLR_IGBYTES_LSB +: 7]);

		// Microsecond time base; zero or one means every cycle
		nx.usTick = 1'b0;
		if ({1'b0, st.usCnt} + 8'h1 >= {1'b0, cycNum}) begin
			nx.usCnt = 7'h0;
			nx.usTick = 1'b1;
		end else begin
			nx.usCnt = st.usCnt + 7'h1;
		end

		// Five-slot arbiter frame
		if (st.gigOnly)
			gigSlots = 3'd5;
		else if (st.ratioSel)
			gigSlots = 3'd4;
		else
			gigSlots = 3'd3;
		nx.slot = (st.slot == 3'd4) ? 3'd0 : st.slot + 3'd1;
		nx.grant = 7'h00;
		if (st.slot < gigSlots) begin
			// Without the port 5 MAC every gig slot goes to port 6
			if (st.gigPtr && PORT5_PRESENT)
				nx.grant[5] = 1'b1;
			else
				nx.grant[6] = 1'b1;
			nx.gigPtr = !st.gigPtr;
		end else begin
			nx.grant[st.lanPtr] = 1'b1;
			nx.lanPtr = (st.lanPtr == 3'd4) ? 3'd0 : st.lanPtr + 3'd1;
		end

		// Frame counters wrap at their width
		for (int p = 0; p < 6; p++) begin
			if (rxGood[p])
				nx.goodCnt[p] = st.goodCnt[p] + 16'h1;
			if (rxBad[p])
				nx.badCnt[p] = st.badCnt[p] + 16'h1;
		end

		nx.dblTagOut = st.dblTag & portMask;
		nx.untag = st.vub[vlanIdx[3:2]][7 * vlanIdx[1:0] +: 7];

		nx.ingAdjValid = ingValid;
		if (ingValid)
			nx.ingAdj = ingComb;
		nx.egAdjValid = egValid;
		if (egValid)
			nx.egAdj = lenAdj(egLen, st.num2[`SSLR_EGSIGN_BIT],
				st.num2[`SSLR_EGBYTES_LSB +: 7]);

		if (regWr) begin
			case (regAddr)
				`SSLR_GC2_OFS: begin
					nx.gigOnly = regWdata[`SSLR_GIGONLY_BIT];
					nx.ratioSel = regWdata[`SSLR_RATIO_BIT];
					nx.dblTag = regWdata[6:0];
				end
				`SSLR_VLAN_UNTAG_MASK_0_3_OFS: nx.vub[0] = regWdata[27:0];
				`SSLR_VLAN_UNTAG_MASK_4_7_OFS: nx.vub[1] = regWdata[27:0];
				`SSLR_VLAN_UNTAG_MASK_8_11_OFS: nx.vub[2] = regWdata[27:0];
				`SSLR_VLAN_UNTAG_MASK_12_15_OFS: nx.vub[3] = regWdata[27:0];
				`SSLR_CTRL_OFS: nx.ctrl = regWdata & `SSLR_CTRL_MASK;
				`SSLR_NUM1_OFS: nx.num1 = regWdata;
				`SSLR_NUM2_OFS: nx.num2 = regWdata;
				`SSLR_ING01_OFS: nx.ing01 = regWdata & `SSLR_ING_MASK;
				default: begin
				end
			endcase
		end

		nx.rdata = 32'h00000000;
		if (regRd) begin
			case (regAddr)
				`SSLR_GC2_OFS: nx.rdata = {22'h0, st.gigOnly, st.ratioSel, 1'b0, st.dblTag};
				`SSLR_PC0_OFS: nx.rdata = {st.badCnt[0], st.goodCnt[0]};
				`SSLR_PC1_OFS: nx.rdata = {st.badCnt[1], st.goodCnt[1]};
				`SSLR_PC2_OFS: nx.rdata = {st.badCnt[2], st.goodCnt[2]};
				`SSLR_PC3_OFS: nx.rdata = {st.badCnt[3], st.goodCnt[3]};
				`SSLR_PC4_OFS: nx.rdata = {st.badCnt[4], st.goodCnt[4]};
				`SSLR_PC5_OFS: nx.rdata = {st.badCnt[5], st.goodCnt[5]};
				`SSLR_VLAN_UNTAG_MASK_0_3_OFS: nx.rdata = {4'h0, st.vub[0]};
				`SSLR_VLAN_UNTAG_MASK_4_7_OFS: nx.rdata = {4'h0, st.vub[1]};
				`SSLR_VLAN_UNTAG_MASK_8_11_OFS: nx.rdata = {4'h0, st.vub[2]};
				`SSLR_VLAN_UNTAG_MASK_12_15_OFS: nx.rdata = {4'h0, st.vub[3]};
				`SSLR_CTRL_OFS: nx.rdata = st.ctrl;
				`SSLR_NUM1_OFS: nx.rdata = st.num1;
				`SSLR_NUM2_OFS: nx.rdata = st.num2;
				`SSLR_ING01_OFS: nx.rdata = st.ing01;
				default: nx.rdata = 32'h00000000;
			endcase
		end

		if (srst) begin
			nx = '0;
			nx.ctrl = `SSLR_CTRL_RST;
			nx.num1 = `SSLR_NUM1_RST;
			nx.num2 = `SSLR_NUM2_RST;
		end
	end

	always_ff @(posedge clk) begin
		if (ce || srst)
			st <= nx;
	end

	assign regRdata = st.rdata;
	assign arbGrant = st.grant;
	assign doubleTagEn = st.dblTagOut;
	assign untagMask = st.untag;
	assign ingAdjLen = st.ingAdj;
	assign ingAdjValid = st.ingAdjValid;
	assign egAdjLen = st.egAdj;
	assign egAdjValid = st.egAdjValid;

	genvar gp;
	generate
		for (gp = 0; gp < 6; gp++) begin : g_storm
			sslr_storm_port #(
				.PRESENT((gp != 5) || PORT5_PRESENT)
			) u_storm (
				.clk(clk),
				.ce(ce),
				.srst(srst),
				.usTick(st.usTick),
				.typeEn(st.ctrl[4 * gp +: 3]),
				.speed(portSpeed[2 * gp +: 2]),
				.budgetSlow(st.num1[15:0]),
				.budgetFast(st.num1[31:16]),
				.budgetGig(st.num2[15:0]),
				.frameBc(frameBc[gp]),
				.frameMc(frameMc[gp]),
				.frameUn(frameUn[gp]),
				.drop(stormDrop[gp])
			);
		end
		for (gp = 0; gp < 2; gp++) begin : g_bucket
			sslr_bucket u_bucket (
				.clk(clk),
				.ce(ce),
				.srst(srst),
				.usTick(st.usTick),
				.period(st.ing01[16 * gp + 10 +: 2]),
				.tokens(st.ing01[16 * gp +: 10]),
				.frameValid(ingValid && ingPort == 3'(gp)),
				.frameLen(ingComb),
				.empty(bucketEmpty[gp])
			);
		end
	endgenerate

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_gig_only;
		ce && st.gigOnly |=> arbGrant[4:0] == 5'h00;
	endproperty
	a_gig_only: assert property (p_gig_only) else $error("lan port got a gig-only slot");

	sequence s_lan_slot;
		ce && !st.gigOnly && st.slot == (st.ratioSel ? 3'd4 : 3'd3);
	endsequence
	property p_ratio;
		s_lan_slot |=> arbGrant[6:5] == 2'b00 && arbGrant[4:0] != 5'h00;
	endproperty
	a_ratio: assert property (p_ratio) else $error("lan slot position wrong");

	property p_dbltag;
		ce |=> doubleTagEn == ($past(st.dblTag) & portMask);
	endproperty
	a_dbltag: assert property (p_dbltag) else $error("double tag output mismatch");

	property p_port5;
		!PORT5_PRESENT |-> !doubleTagEn[5] && !arbGrant[5] && !stormDrop[5];
	endproperty
	a_port5: assert property (p_port5) else $error("absent port 5 acted on");

	property p_bad_cnt;
		ce && rxBad[0] |=> st.badCnt[0] == $past(st.badCnt[0]) + 16'h1;
	endproperty
	a_bad_cnt: assert property (p_bad_cnt) else $error("bad counter missed frame");

	property p_good_cnt;
		ce && rxGood[3] |=> st.goodCnt[3] == $past(st.goodCnt[3]) + 16'h1;
	endproperty
	a_good_cnt: assert property (p_good_cnt) else $error("good counter missed frame");

	sequence s_pc_read;
		ce && regRd && regAddr == `SSLR_PC3_OFS;
	endsequence
	property p_pc_read;
		s_pc_read |=> regRdata == {$past(st.badCnt[3]), $past(st.goodCnt[3])};
	endproperty
	a_pc_read: assert property (p_pc_read) else $error("counter read mismatch");

	property p_vlan;
		ce && regWr && regAddr == `SSLR_VLAN_UNTAG_MASK_8_11_OFS |=> st.vub[2] == $past(regWdata[27:0]);
	endproperty
	a_vlan: assert property (p_vlan) else $error("untag mask write lost");

	property p_us;
		ce && cycNum > 7'd1 && st.usTick |=> !st.usTick && st.usCnt == 7'h1;
	endproperty
	a_us: assert property (p_us) else $error("microsecond tick period wrong");

	property p_ing_add;
		ce && ingValid && !st.num2[`SSLR_IGSIGN_BIT] && ingLen < 16'hFF00 |=>
			ingAdjValid && ingAdjLen == $past(ingLen) + {9'h0, $past(st.num2[30:24])};
	endproperty
	a_ing_add: assert property (p_ing_add) else $error("ingress add wrong");

	property p_eg_sub;
		ce && egValid && st.num2[`SSLR_EGSIGN_BIT] && egLen > 16'h0080 |=>
			egAdjValid && egAdjLen == $past(egLen) - {9'h0, $past(st.num2[22:16])};
	endproperty
	a_eg_sub: assert property (p_eg_sub) else $error("egress subtract wrong");
endmodule

// >>> test/sslr_mac_model.sv
/*
 Stand-in for the port MACs and frame engine: frame pulses and speeds.
 Assumes the bench calls its tasks and the bank samples on rising clk.
*/
`timescale 1ns/1ps
module sslr_mac_model (
	input wire logic clk, // core clock
	output logic [5:0] rxGood, // good frame pulses
	output logic [5:0] rxBad, // bad frame pulses
	output logic [11:0] portSpeed, // two bits per port
	output logic [5:0] frameBc, // broadcast pulses
	output logic [5:0] frameMc, // multicast pulses
	output logic [5:0] frameUn // unknown pulses
);
	initial begin
		rxGood = '0;
		rxBad = '0;
		frameBc = '0;
		frameMc = '0;
		frameUn = '0;
		// Port 0 at 100M, port 1 at 1G, others 10M
		portSpeed = 12'h009;
	end
	// One cycle per frame, then a quiet cycle before the next
	task automatic rx(input int p, input bit good);
		@(posedge clk);
		if (good) rxGood[p] <= 1'b1;
		else rxBad[p] <= 1'b1;
		@(posedge clk);
		rxGood <= '0;
		rxBad <= '0;
	endtask
	task automatic storm(input int p, input int t);
		@(posedge clk);
		case (t)
			2: frameBc[p] <= 1'b1;
			1: frameMc[p] <= 1'b1;
			default: frameUn[p] <= 1'b1;
		endcase
		@(posedge clk);
		frameBc <= '0;
		frameMc <= '0;
		frameUn <= '0;
	endtask
endmodule

// >>> test/tb.sv
/*
 Self-checking bench of the statistics and storm limit bank.
 Assumes the partner model drives frame pulses and ce stays high except while one frame is sent frozen.
*/
`timescale 1ns/1ps
`include "sslr_defs.svh"
module tb;
	logic clk, srst, ce, regWr, regRd, ingValid, egValid;
	logic [31:0] regAddr, regWdata, regRdata, d, w;
	logic [5:0] rxGood, rxBad, frameBc, frameMc, frameUn, stormDrop;
	logic [11:0] portSpeed;
	logic [2:0] ingPort;
	logic [15:0] ingLen, ingAdjLen, egLen, egAdjLen, el, il;
	logic ingAdjValid, egAdjValid;
	logic [1:0] bucketEmpty;
	logic [3:0] vlanIdx;
	logic [6:0] untagMask, doubleTagEn, arbGrant;
	logic [31:0] seed = 32'h00006F87;
	logic [27:0] vub [4];
	logic [15:0] good [6], bad [6];
	logic [31:0] rwa [9] = '{`SSLR_GC2_OFS, `SSLR_VLAN_UNTAG_MASK_0_3_OFS, `SSLR_VLAN_UNTAG_MASK_4_7_OFS, `SSLR_VLAN_UNTAG_MASK_8_11_OFS,
		`SSLR_VLAN_UNTAG_MASK_12_15_OFS, `SSLR_CTRL_OFS, `SSLR_NUM1_OFS, `SSLR_NUM2_OFS, `SSLR_ING01_OFS};
	// Port, type, drop as p*100+t*10+d
	int sq [12] = '{10, 20, 20, 20, 21, 110, 110, 111, 120, 200, 200, 201};
	int err_count = 0, n_compared = 0, p, n;
	sslr_top u_dut (.clk(clk), .ce(ce), .srst(srst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.rxGood(rxGood), .rxBad(rxBad), .portSpeed(portSpeed), .frameBc(frameBc),
		.frameMc(frameMc), .frameUn(frameUn), .stormDrop(stormDrop), .ingValid(ingValid),
		.ingPort(ingPort), .ingLen(ingLen), .ingAdjLen(ingAdjLen), .ingAdjValid(ingAdjValid),
		.bucketEmpty(bucketEmpty), .egValid(egValid), .egLen(egLen), .egAdjLen(egAdjLen),
		.egAdjValid(egAdjValid), .vlanIdx(vlanIdx), .untagMask(untagMask),
		.doubleTagEn(doubleTagEn), .arbGrant(arbGrant));
	sslr_mac_model u_mac (.clk(clk), .rxGood(rxGood), .rxBad(rxBad), .portSpeed(portSpeed),
		.frameBc(frameBc), .frameMc(frameMc), .frameUn(frameUn));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] rst_val(input logic [31:0] a);
		if (a == `SSLR_CTRL_OFS) return 32'h7C000000;
		if (a == `SSLR_NUM1_OFS) return 32'hFFFFFFFF;
		if (a == `SSLR_NUM2_OFS) return 32'h1818FFFF;
		return 32'h00000000;
	endfunction
	function automatic logic [31:0] rw_mask(input logic [31:0] a);
		if (a == `SSLR_GC2_OFS) return 32'h0000037F;
		if (a == `SSLR_CTRL_OFS) return 32'h7F777777;
		if (a == `SSLR_ING01_OFS) return 32'h7FFF7FFF;
		if (a == `SSLR_NUM1_OFS || a == `SSLR_NUM2_OFS) return 32'hFFFFFFFF;
		return 32'h0FFFFFFF;
	endfunction
	// Saturates rather than wraps, so a short frame never meters huge
	function automatic logic [15:0] adj(input logic [15:0] l, input logic s, input logic [6:0] b);
		if (s) return (l < b) ? 16'h0000 : l - b;
		return ({1'b0, l} + b > 17'h0FFFF) ? 16'hFFFF : l + b;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	task automatic frame(input logic [2:0] pt, input logic [15:0] li, input logic [15:0] le);
		@(posedge clk);
		ingValid <= 1'b1;
		ingPort <= pt;
		ingLen <= li;
		egValid <= 1'b1;
		egLen <= le;
		@(posedge clk);
		ingValid <= 1'b0;
		egValid <= 1'b0;
		#1;
	endtask
	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		print_verdict();
	end
	initial begin
		{srst, ce, regWr, regRd, ingValid, egValid} = 6'b110000;
		{regAddr, regWdata, ingLen, egLen, ingPort, vlanIdx} = '0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			rd(`SSLR_GC2_OFS + 4 * i, d);
			chk("reset value", rst_val(`SSLR_GC2_OFS + 4 * i), d);
		end
		rd(32'h10110200, d);
		chk("unmapped", 32'h00000000, d);
		for (int i = 0; i < 9; i++) begin
			w = rnd();
			wr(rwa[i], w);
			rd(rwa[i], d);
			chk("readback", w & rw_mask(rwa[i]), d);
			if (i > 0 && i < 5) vub[i - 1] = w[27:0];
		end
		wr(`SSLR_PC3_OFS, rnd());
		wr(32'h10110200, rnd());
		for (int i = 0; i < 6; i++) begin
			good[i] = 16'h0000;
			bad[i] = 16'h0000;
		end
		for (int i = 0; i < 40; i++) begin
			p = rnd() % 6;
			w = rnd();
			u_mac.rx(p, w[0]);
			if (w[0]) good[p]++;
			else bad[p]++;
		end
		for (int i = 0; i < 6; i++) begin
			rd(`SSLR_PC0_OFS + 4 * i, d);
			chk("frame counts", {bad[i], good[i]}, d);
		end
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			vlanIdx <= i[3:0];
			@(posedge clk);
			#1 chk("untag mask", {25'h0, vub[i / 4][7 * (i % 4) +: 7]}, {25'h0, untagMask});
		end
		for (int i = 0; i < 3; i++) begin
			w = (i << 8) | (rnd() & 32'h7F);
			wr(`SSLR_GC2_OFS, w);
			repeat (3) @(posedge clk);
			n = 0;
			repeat (50) begin
				@(posedge clk);
				#1;
				n += arbGrant[6] | arbGrant[5];
			end
			chk("gig slots", 30 + 10 * i, n);
			chk("double tag", w[6:0], doubleTagEn);
		end
		for (int i = 0; i < 12; i++) begin
			w = rnd();
			wr(`SSLR_NUM2_OFS, {w[31:16], 16'h0002});
			il = (i % 3 == 0) ? {9'h0, w[6:0]} : (i % 3 == 1) ? (16'hFFF0 | w[3:0]) : w[15:0];
			el = (i % 3 == 0) ? {9'h0, w[14:8]} : (i % 3 == 1) ? (16'hFFF0 | w[11:8]) : w[23:8];
			frame(3'h3, il, el);
			chk("ingress valid", 1'b1, ingAdjValid);
			chk("ingress length", adj(il, w[31], w[30:24]), ingAdjLen);
			chk("egress valid", 1'b1, egAdjValid);
			chk("egress length", adj(el, w[23], w[22:16]), egAdjLen);
		end
		// Mid-run reset so every storm window starts from zero
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		// Frame seen while frozen must not count
		ce <= 1'b0;
		u_mac.rx(0, 1'b1);
		ce <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(`SSLR_PC0_OFS + 4 * i, d);
			chk("cleared counts", 32'h00000000, d);
		end
		rd(`SSLR_NUM2_OFS, d);
		chk("reset budget", `SSLR_NUM2_RST, d);
		wr(`SSLR_CTRL_OFS, 32'h01000124);
		wr(`SSLR_NUM1_OFS, 32'h00030002);
		wr(`SSLR_NUM2_OFS, 32'h18180002);
		for (int i = 0; i < 12; i++) begin
			u_mac.storm(sq[i] / 100, (sq[i] / 10) % 10);
			#1 chk("storm drop", sq[i] % 10, stormDrop[sq[i] / 100]);
		end
		repeat (10001) @(posedge clk);
		u_mac.storm(1, 1);
		#1 chk("storm new window", 1'b0, stormDrop[1]);
		wr(`SSLR_ING01_OFS, 32'h00000C00);
		frame(3'h0, 16'hFFFF, 16'h0000);
		repeat (20) @(posedge clk);
		#1 chk("bucket drained", 2'b01, bucketEmpty);
		wr(`SSLR_ING01_OFS, 32'h00000C0A);
		repeat (20) @(posedge clk);
		#1 chk("bucket refilled", 2'b00, bucketEmpty);
		print_verdict();
	end
endmodule
